/* File: bench/analog_side.sv */
// Far-side analog threshold comparators, behavioural
`timescale 1ns/1ps
module analog_side (
	// Sensed levels in mV, degrees C and mA
	input  int   adp_mv,
	input  int   sys_mv,
	input  int   max_mv,
	input  int   bat_mv,
	input  int   temp_c,
	input  int   iadp_ma,
	input  int   ibat_ma,
	input  logic one_cell,
	// Comparator flags
	output logic adp_above_ovp,
	output logic adp_below_release,
	output logic bat_above_bov,
	output logic bat_below_release,
	output logic sys_above_ovp,
	output logic sys_below_release,
	output logic woc_adapter_trip,
	output logic woc_battery_trip,
	output logic temp_above_high,
	output logic temp_below_low,
	output logic bat_above_5v2
);
	int bov_mv;
	// Margin follows cell count
	assign bov_mv            = max_mv * (one_cell ? 4 : 2) / 100;
	// Adapter, battery, system and temperature faults have separate trip and release levels
	assign adp_above_ovp     = adp_mv > 23400;
	assign adp_below_release = adp_mv < 23040;
	assign bat_above_bov     = bat_mv > max_mv + bov_mv;
	assign bat_below_release = bat_mv < max_mv + bov_mv / 2;
	assign sys_above_ovp     = sys_mv > max_mv + 800;
	assign sys_below_release = sys_mv < max_mv + 500;
	assign woc_adapter_trip  = iadp_ma > 12000;
	assign woc_battery_trip  = ibat_ma > 20000;
	assign temp_above_high   = temp_c > 140;
	assign temp_below_low    = temp_c < 120;
	assign bat_above_5v2     = bat_mv > 5200;
endmodule : analog_side

/* File: bench/prot_checker_sva.sv */
// Port-level assertions for the protection supervisor
`timescale 1ns/1ps
module prot_checker
	import chg_prot_pkg::*;
(
	// Clock, reset, enable
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              ce,
	// Register port
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [REG_DW-1:0] reg_rdata,
	// Flags
	input wire logic              sys_above_ovp,
	input wire logic              temp_above_high,
	input wire logic              bat_above_5v2,
	// Outputs
	input wire logic              shared_out,
	input wire logic              shared_out_oe,
	input wire logic              switching_enable,
	input wire logic              input_isolation_switch,
	input wire logic              adapter_valid,
	input wire logic              reverse_power_mode,
	input wire logic              comparator_enable,
	input wire logic              startup_retry
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_hot_stops_switch: assert property ((temp_above_high && ce)[*6] |-> !switching_enable)
		else $error("switching while hot");
	a_sys_stops_switch: assert property ((sys_above_ovp && ce)[*6] |-> !switching_enable)
		else $error("switching during rail fault");
	a_iso_valid_pair: assert property (input_isolation_switch == adapter_valid)
		else $error("isolation and adapter-valid differ");
	a_iso_stops_switch: assert property (!input_isolation_switch |-> !switching_enable)
		else $error("switching while isolated");
	a_off_mode_idle: assert property (!shared_out_oe |-> !shared_out && !comparator_enable
		&& !reverse_power_mode)
		else $error("idle pin mode not idle");
	a_good_needs_rev: assert property (shared_out_oe && !comparator_enable |-> !shared_out
		|| reverse_power_mode)
		else $error("good output without reverse mode");
	a_rev_needs_bat: assert property ($rose(reverse_power_mode) |-> $past(bat_above_5v2, 3))
		else $error("reverse mode on low battery");
	a_retry_single: assert property (startup_retry |=> !startup_retry)
		else $error("retry pulse too long");
	a_retry_restore: assert property (startup_retry && ce |=> input_isolation_switch
		&& adapter_valid)
		else $error("no restart after retry");
	a_info_layout: assert property (ce && reg_addr == OFS_INFO_ONE |=> reg_rdata[15:7] == 9'h000
		&& reg_rdata[4:0] == 5'h00 && reg_rdata[6] == reg_rdata[5])
		else $error("status word layout wrong");

	// Main scenarios reached
	c_rev_pin: cover property (reverse_power_mode && !comparator_enable);
	c_retry: cover property (startup_retry);
	c_isolated: cover property (!input_isolation_switch && !adapter_valid);
endmodule : prot_checker

bind charger_fault_protection_supervisor prot_checker u_prot_checker (.clk, .arst_n, .ce,
	.reg_addr, .reg_rdata, .sys_above_ovp, .temp_above_high, .bat_above_5v2, .shared_out,
	.shared_out_oe,
	.switching_enable, .input_isolation_switch, .adapter_valid, .reverse_power_mode,
	.comparator_enable, .startup_retry);

/* File: bench/tb_top.sv */
// Self-checking testbench for the protection supervisor
`timescale 1ns/1ps
module tb_top;
	import chg_prot_pkg::*;
	// ------------------------------------------------------------
	// Stimulus, model state and counters
	// ------------------------------------------------------------
	localparam int RL = 300;
	localparam int RS = 150;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, pin = 1'b0;
	logic cmp = 1'b0, reached = 1'b0, bsw_req = 1'b0, one = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, c1 = 16'h0000, c2 = 16'h0000, d;
	logic adp_above_ovp, adp_below_release, bat_above_bov, bat_below_release, sys_above_ovp;
	logic sys_below_release, woc_adapter_trip, woc_battery_trip, temp_above_high;
	logic temp_below_low, bat_above_5v2, shared_out, shared_out_oe, switching_enable;
	logic input_isolation_switch, adapter_valid, battery_switch, reverse_power_mode;
	logic comparator_enable, bov_margin_wide, startup_retry;
	int adp_mv = 20000, sys_mv = 12000, max_mv = 12000, bat_mv = 8000, temp_c = 50;
	int iadp = 0, ibat = 0, seed = 32'hf30e2a5e, mismatches = 0, n_compared = 0, k, n;
	int adp_f = 0, bov_f = 0, sys_f = 0, ot_f = 0, woc_f = 0;

	// Clock, 100 ns period
	always #50 clk = ~clk;

	analog_side u_analog_side (.adp_mv, .sys_mv, .max_mv, .bat_mv, .temp_c, .iadp_ma(iadp),
		.ibat_ma(ibat), .one_cell(one), .adp_above_ovp, .adp_below_release, .bat_above_bov,
		.bat_below_release, .sys_above_ovp, .sys_below_release, .woc_adapter_trip,
		.woc_battery_trip, .temp_above_high, .temp_below_low, .bat_above_5v2);

	charger_fault_protection_supervisor #(.BOV_CYCLES(20), .WOC_WINDOW_CYCLES(2000),
		.RETRY_LONG_CYCLES(RL), .RETRY_SHRT_CYCLES(RS)) u_charger_fault_protection_supervisor (
		.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .adp_above_ovp,
		.adp_below_release, .bat_above_bov, .bat_below_release, .sys_above_ovp,
		.sys_below_release, .woc_adapter_trip, .woc_battery_trip, .temp_above_high,
		.temp_below_low, .bat_above_5v2, .comparator_above_ref(cmp), .reverse_output_reached(reached),
		.reverse_power_enable_pin(pin), .one_cell_config(one), .battery_switch_request(bsw_req),
		.shared_out, .shared_out_oe, .switching_enable, .input_isolation_switch, .adapter_valid,
		.battery_switch, .reverse_power_mode, .comparator_enable, .bov_margin_wide, .startup_retry);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int cyc);
		repeat (cyc) @(negedge clk);
	endtask : wt

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		if (a == OFS_CTRL_ONE) c1 = v;
		if (a == OFS_CTRL_TWO) c2 = v;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(negedge clk);
		reg_addr = a;
		wt(2);
		chk(reg_rdata, exp);
	endtask : rd

	// Expected reverse mode
	function automatic logic rev_exp();
		return c1[11] && bat_mv > 5200 && (!c2[3] || pin);
	endfunction : rev_exp

	// Compare all outputs except the read data with the model
	task automatic chk_out(input int cyc);
		logic sw, iso, sh;
		wt(cyc);
		sw = !(adp_f || bov_f || sys_f || ot_f || woc_f);
		iso = !(adp_f || woc_f);
		sh = (c1[11] && c2[3]) ? rev_exp() && reached : !c2[3] && (cmp ^ c2[2]);
		chk({6'h00, switching_enable, input_isolation_switch, adapter_valid, battery_switch,
			reverse_power_mode, comparator_enable, shared_out_oe, shared_out, bov_margin_wide,
			startup_retry}, {6'h00, sw, iso, iso, bsw_req || adp_f != 0, rev_exp(), !c2[3],
			c1[11] || !c2[3], sh, one, 1'b0});
	endtask : chk_out

	task automatic complete_run();
		$display("compared=%0d mismatches=%0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		wt(4);
		arst_n = 1'b1;
		chk_out(6);
		rd(OFS_CTRL_ONE, CTRL_ONE_RESET);
		rd(OFS_CTRL_TWO, CTRL_TWO_RESET);
		wr(OFS_INFO_ONE, 16'hffff);
		rd(OFS_INFO_ONE, 16'h0000);
		rd(8'h3b, 16'h0000);
		// Pin modes, polarity, pin and battery
		for (k = 0; k < 32; k++) begin
			bat_mv = k[4] ? 8000 : 4000;
			pin = k[3];
			{cmp, reached, bsw_req, one} = 4'($random(seed));
			d = 16'($random(seed));
			d[11] = k[0];
			wr(OFS_CTRL_ONE, d);
			wr(OFS_CTRL_TWO, {12'h000, k[1], k[2], 2'b00});
			chk_out(6);
			rd(OFS_INFO_ONE, rev_exp() ? 16'h0060 : 16'h0000);
			rd(OFS_CTRL_ONE, c1);
		end
		wr(OFS_CTRL_ONE, 16'h0000);
		wr(OFS_CTRL_TWO, 16'h0000);
		// Adapter overvoltage and release
		adp_mv = 23500;
		chk_out(80);
		adp_f = 1;
		chk_out(40);
		adp_mv = 23200;
		chk_out(1200);
		adp_mv = 20000;
		chk_out(950);
		adp_f = 0;
		chk_out(100);
		// Battery overvoltage: two-cell, one-cell, disabled
		one = 1'b0;
		bat_mv = 12300;
		wt(10);
		bat_mv = 12000;
		chk_out(30);
		bat_mv = 12300;
		chk_out(15);
		bov_f = 1;
		chk_out(15);
		bat_mv = 12150;
		chk_out(60);
		bat_mv = 12000;
		chk_out(10);
		bov_f = 0;
		chk_out(20);
		one = 1'b1;
		bat_mv = 12300;
		chk_out(60);
		wr(OFS_CTRL_TWO, 16'h0001);
		bat_mv = 12600;
		chk_out(60);
		bat_mv = 12000;
		wr(OFS_CTRL_TWO, 16'h0000);
		// System overvoltage, no debounce
		sys_mv = 12900;
		sys_f = 1;
		chk_out(6);
		sys_mv = 12600;
		chk_out(20);
		sys_mv = 12400;
		sys_f = 0;
		chk_out(6);
		// Over-temperature with delayed restart
		temp_c = 150;
		ot_f = 1;
		chk_out(8);
		temp_c = 130;
		chk_out(1200);
		temp_c = 100;
		chk_out(950);
		ot_f = 0;
		chk_out(100);
		// Overcurrent shutdown and retry, both sources and waits
		for (k = 0; k < 2; k++) begin
			wr(OFS_CTRL_TWO, {4'h0, k[0], 11'h000});
			iadp = 13000 * (1 - k);
			ibat = 21000 * k;
			chk_out(550);
			woc_f = 1;
			chk_out(60);
			iadp = 0;
			ibat = 0;
			for (n = 0; n < 400 && startup_retry !== 1'b1; n++)
				@(negedge clk);
			chk(16'(n >= (k ? RS : RL) - 12 && n <= (k ? RS : RL)), 16'h0001);
			woc_f = 0;
			chk_out(2);
		end
		// Six counts, window lapses, six more: no shutdown
		iadp = 13000;
		wt(550);
		iadp = 0;
		wt(2000);
		iadp = 13000;
		chk_out(550);
		iadp = 0;
		wr(OFS_CTRL_TWO, 16'h0002);
		iadp = 13000;
		chk_out(800);
		iadp = 0;
		complete_run();
	end

	// Watchdog against a hang
	initial begin
		#3000000;
		mismatches++;
		complete_run();
	end
endmodule : tb_top

/* File: design/charger_fault_protection_supervisor.sv */
// Protection supervisor and shared-pin mode selection for the charger controller
//
// Notes on behaviour
// - Enable bit 0, comparator-disable 0: reverse power off, comparator on shared pins.
// - Enable bit 0, comparator-disable 1: reverse power and comparator off, pins idle.
// - Enable 1, disable 0: comparator stays; reverse power above 5.2V, no good output.
// - Active reverse power shows 11 in status bits 6:5 at offset 0x3a.
// - Both 1: pins become enable input and good output; reverse needs pin, bit, battery.
// - Adapter above 23.4V beyond 10us: isolate, drop adapter-valid, stop, battery switch on.
// - Adapter below 23.04V beyond 100us after fault: reconnect input and resume switching.
// - Battery above max setting plus margin for 1ms: battery fault, stop switching.
// - Margin is 4% for one cell, 2% for two to four cells.
// - Battery fault clears after 1ms below max setting plus half the margin.
// - Control two bit 0 disables battery overvoltage protection entirely.
// - System rail 800mV above max setting: system fault, stop switching.
// - System fault clears immediately once rail falls 300mV below threshold.
// - Way-overcurrent flagged above 12A adapter or 20A battery discharge current.
// - Overcurrent trips counted at most once per 10us interval.
// - Seven counts within 50ms: isolate input, drop adapter-valid, stop switching.
// - After shutdown wait 1.3s or 150ms by control two bit 11, then retry start-up.
// - Control two bit 1 disables way-overcurrent counting and shutdown.
// - Switching stops while junction temperature flag reads above 140 degrees.
// - Once below lower threshold, wait 100us then restart switching.
// - Comparator output high when input above reference; control two bit 2 inverts.
// - In reverse mode with both bits 1, good output high once reverse output reaches its setting.
`timescale 1ns/1ps
module charger_fault_protection_supervisor
	import chg_prot_pkg::*;
#(
	parameter int unsigned BOV_CYCLES        = BOV_CYC,
	parameter int unsigned WOC_WINDOW_CYCLES = WOC_WIN_CYC,
	parameter int unsigned RETRY_LONG_CYCLES = WOC_RETRY_LONG_CYC,
	parameter int unsigned RETRY_SHRT_CYCLES = WOC_RETRY_SHRT_CYC
) (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              ce,
	// Register port from the serial interface engine
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	output logic      [REG_DW-1:0] reg_rdata,
	// Analog comparator flags, asynchronous
	input  wire logic              adp_above_ovp,
	input  wire logic              adp_below_release,
	input  wire logic              bat_above_bov,
	input  wire logic              bat_below_release,
	input  wire logic              sys_above_ovp,
	input  wire logic              sys_below_release,
	input  wire logic              woc_adapter_trip,
	input  wire logic              woc_battery_trip,
	input  wire logic              temp_above_high,
	input  wire logic              temp_below_low,
	input  wire logic              bat_above_5v2,
	input  wire logic              comparator_above_ref,
	input  wire logic              reverse_output_reached,
	// Shared pin 20, input only
	input  wire logic              reverse_power_enable_pin,
	// Configuration and requests from same-clock logic
	input  wire logic              one_cell_config,
	input  wire logic              battery_switch_request,
	// Shared pin 26
	output logic                   shared_out,
	output logic                   shared_out_oe,
	// Power stage controls
	output logic                   switching_enable,
	output logic                   input_isolation_switch,
	output logic                   adapter_valid,
	output logic                   battery_switch,
	output logic                   reverse_power_mode,
	output logic                   comparator_enable,
	output logic                   bov_margin_wide,
	output logic                   startup_retry
);

	// ------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------
	localparam int unsigned NSYNC = 14;

	logic [1:0]       rst_sync_q;
	logic             rst_n;
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	assign async_in = {reverse_power_enable_pin, reverse_output_reached, comparator_above_ref,
		bat_above_5v2, temp_below_low, temp_above_high, woc_battery_trip, woc_adapter_trip,
		sys_below_release, sys_above_ovp, bat_below_release, bat_above_bov,
		adp_below_release, adp_above_ovp};

	// Two flip-flops per flag ahead of any timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (ce) begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
		end
	end

	logic s_adp_ov, s_adp_rel, s_bat_ov, s_bat_rel, s_sys_ov, s_sys_rel;
	logic s_woc_a, s_woc_b, s_hot, s_cool, s_bat_5v2, s_cmp, s_rev_ok, s_rev_pin;
	assign {s_rev_pin, s_rev_ok, s_cmp, s_bat_5v2, s_cool, s_hot, s_woc_b, s_woc_a,
		s_sys_rel, s_sys_ov, s_bat_rel, s_bat_ov, s_adp_rel, s_adp_ov} = sync2_q;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [REG_DW-1:0] ctrl_one_q;
	logic [REG_DW-1:0] ctrl_two_q;
	logic [REG_DW-1:0] info_one;
	logic              rev_active;

	// Software writes to the two control words
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_one_q <= CTRL_ONE_RESET;
			ctrl_two_q <= CTRL_TWO_RESET;
		end else if (ce && reg_wr) begin
			if (reg_addr == OFS_CTRL_ONE) begin
				ctrl_one_q <= reg_wdata;
			end
			if (reg_addr == OFS_CTRL_TWO) begin
				ctrl_two_q <= reg_wdata;
			end
		end
	end

	// Status word: only the mode field is live
	always_comb begin
		info_one = '0;
		info_one[I1_MODE_HI_BIT:I1_MODE_LO_BIT] = rev_active ? I1_MODE_REVERSE
			: I1_MODE_IDLE;
	end

	// Registered read data, zero for unmapped offsets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (ce) begin
			case (reg_addr)
				OFS_INFO_ONE: reg_rdata <= info_one;
				OFS_CTRL_ONE: reg_rdata <= ctrl_one_q;
				OFS_CTRL_TWO: reg_rdata <= ctrl_two_q;
				default:      reg_rdata <= '0;
			endcase
		end
	end

	logic rev_en_bit, cmp_dis_bit, cmp_pol_bit, bov_dis_bit, woc_dis_bit, retry_short_bit;
	assign rev_en_bit      = ctrl_one_q[C1_REV_EN_BIT];
	assign cmp_dis_bit     = ctrl_two_q[C2_CMP_DIS_BIT];
	assign cmp_pol_bit     = ctrl_two_q[C2_CMP_POL_BIT];
	assign bov_dis_bit     = ctrl_two_q[C2_BOV_DIS_BIT];
	assign woc_dis_bit     = ctrl_two_q[C2_WOC_DIS_BIT];
	assign retry_short_bit = ctrl_two_q[C2_WOC_RETRY_BIT];

	// ------------------------------------------------------------
	// Shared pin mode and reverse power
	// ------------------------------------------------------------
	pin_mode_t mode;
	logic      rev_ok_d;
	logic      cmp_on;

	always_comb begin
		case ({rev_en_bit, cmp_dis_bit})
			2'h0:    mode = MODE_CMP_ONLY;
			2'h1:    mode = MODE_ALL_OFF;
			2'h2:    mode = MODE_REV_CMP;
			default: mode = MODE_REV_PIN;
		endcase
	end

	// Reverse power conditions per mode
	always_comb begin
		case (mode)
			MODE_REV_CMP: rev_ok_d = s_bat_5v2;
			MODE_REV_PIN: rev_ok_d = s_bat_5v2 && s_rev_pin;
			default:      rev_ok_d = 1'b0;
		endcase
	end
	assign cmp_on = (mode == MODE_CMP_ONLY) || (mode == MODE_REV_CMP);

	// Registered mode outputs and shared output pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rev_active        <= 1'b0;
			comparator_enable <= 1'b0;
			shared_out        <= 1'b0;
			shared_out_oe     <= 1'b0;
		end else if (ce) begin
			rev_active        <= rev_ok_d;
			comparator_enable <= cmp_on;
			shared_out_oe     <= (mode != MODE_ALL_OFF);
			if (cmp_on) begin
				shared_out <= s_cmp ^ cmp_pol_bit;
			end else if (mode == MODE_REV_PIN) begin
				shared_out <= rev_ok_d && s_rev_ok;
			end else begin
				shared_out <= 1'b0;
			end
		end
	end
	assign reverse_power_mode = rev_active;

	// ------------------------------------------------------------
	// Adapter, battery, system and temperature faults
	// ------------------------------------------------------------
	logic adp_ov_q, bat_ov_q, sys_ov_q, ot_q;
	logic adp_set, adp_clr, bat_set, bat_clr, ot_clr;

	hold_timer #(.W(32)) u_adp_qual (
		.clk(clk), .rst_n(rst_n), .ce(ce), .clr(adp_ov_q), .level(s_adp_ov),
		.limit(32'(ADP_QUAL_CYC)), .done(adp_set)
	);
	hold_timer #(.W(32)) u_adp_rel (
		.clk(clk), .rst_n(rst_n), .ce(ce), .clr(!adp_ov_q), .level(s_adp_rel),
		.limit(32'(ADP_REL_CYC)), .done(adp_clr)
	);
	hold_timer #(.W(32)) u_bat_qual (
		.clk(clk), .rst_n(rst_n), .ce(ce), .clr(bat_ov_q || bov_dis_bit), .level(s_bat_ov),
		.limit(32'(BOV_CYCLES)), .done(bat_set)
	);
	hold_timer #(.W(32)) u_bat_rel (
		.clk(clk), .rst_n(rst_n), .ce(ce), .clr(!bat_ov_q), .level(s_bat_rel),
		.limit(32'(BOV_CYCLES)), .done(bat_clr)
	);
	hold_timer #(.W(32)) u_ot_rel (
		.clk(clk), .rst_n(rst_n), .ce(ce), .clr(!ot_q || s_hot), .level(s_cool),
		.limit(32'(OT_RESTART_CYC)), .done(ot_clr)
	);

	// Adapter overvoltage latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adp_ov_q <= 1'b0;
		end else if (ce) begin
			if (adp_set) begin
				adp_ov_q <= 1'b1;
			end else if (adp_clr) begin
				adp_ov_q <= 1'b0;
			end
		end
	end

	// Battery overvoltage latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bat_ov_q <= 1'b0;
		end else if (ce) begin
			if (bov_dis_bit) begin
				bat_ov_q <= 1'b0;
			end else if (bat_set) begin
				bat_ov_q <= 1'b1;
			end else if (bat_clr) begin
				bat_ov_q <= 1'b0;
			end
		end
	end

	// System overvoltage latch, no debounce on release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_ov_q <= 1'b0;
		end else if (ce) begin
			if (s_sys_ov) begin
				sys_ov_q <= 1'b1;
			end else if (s_sys_rel) begin
				sys_ov_q <= 1'b0;
			end
		end
	end

	// Over-temperature latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ot_q <= 1'b0;
		end else if (ce) begin
			if (s_hot) begin
				ot_q <= 1'b1;
			end else if (ot_clr) begin
				ot_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Way-overcurrent counting and retry
	// ------------------------------------------------------------
	woc_state_t  woc_state_q;
	logic [31:0] slot_q;
	logic [31:0] win_q;
	logic [31:0] wait_q;
	logic [2:0]  woc_cnt_q;
	logic        woc_trip;
	logic        woc_count;
	logic [31:0] retry_cyc;

	assign woc_trip  = s_woc_a || s_woc_b;
	assign woc_count = woc_trip && (slot_q == 32'h0) && (woc_state_q == WOC_WATCH);
	assign retry_cyc = retry_short_bit ? 32'(RETRY_SHRT_CYCLES) : 32'(RETRY_LONG_CYCLES);

	// Count trips, one per slot, inside a window opened by the first count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			woc_state_q   <= WOC_WATCH;
			slot_q        <= '0;
			win_q         <= '0;
			wait_q        <= '0;
			woc_cnt_q     <= '0;
			startup_retry <= 1'b0;
		end else if (ce) begin
			startup_retry <= 1'b0;
			if (slot_q != 32'h0) begin
				slot_q <= slot_q - 32'h1;
			end
			if (woc_dis_bit) begin
				woc_state_q <= WOC_WATCH;
				slot_q      <= '0;
				win_q       <= '0;
				woc_cnt_q   <= '0;
				wait_q      <= '0;
			end else begin
				case (woc_state_q)
					WOC_WATCH: begin
						if (win_q != 32'h0) begin
							win_q <= win_q - 32'h1;
						end else begin
							woc_cnt_q <= '0;
						end
						if (woc_count) begin
							slot_q <= 32'(WOC_SLOT_CYC) - 32'h1;
							if (woc_cnt_q == 3'(WOC_TRIP_COUNT - 1) && win_q != 32'h0) begin
								woc_state_q <= WOC_SHUTDOWN;
								wait_q      <= retry_cyc;
								woc_cnt_q   <= '0;
								win_q       <= '0;
							end else if (win_q == 32'h0 || woc_cnt_q == 3'h0) begin
								woc_cnt_q <= 3'h1;
								win_q     <= 32'(WOC_WINDOW_CYCLES) - 32'h1;
							end else begin
								woc_cnt_q <= woc_cnt_q + 3'h1;
							end
						end
					end
					WOC_SHUTDOWN: begin
						if (wait_q > 32'h1) begin
							wait_q <= wait_q - 32'h1;
						end else begin
							wait_q        <= '0;
							woc_state_q   <= WOC_WATCH;
							startup_retry <= 1'b1;
						end
					end
					default: woc_state_q <= WOC_WATCH;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Power stage outputs
	// ------------------------------------------------------------
	logic woc_off;
	assign woc_off = (woc_state_q == WOC_SHUTDOWN);

	// Registered switch and gate controls
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			switching_enable       <= 1'b0;
			input_isolation_switch <= 1'b0;
			adapter_valid          <= 1'b0;
			battery_switch         <= 1'b0;
			bov_margin_wide        <= 1'b0;
		end else if (ce) begin
			switching_enable       <= !(adp_ov_q || bat_ov_q || sys_ov_q || woc_off || ot_q);
			input_isolation_switch <= !(adp_ov_q || woc_off);
			adapter_valid          <= !(adp_ov_q || woc_off);
			battery_switch         <= adp_ov_q || battery_switch_request;
			bov_margin_wide        <= one_cell_config;
		end
	end

endmodule : charger_fault_protection_supervisor

/* File: design/hold_timer.sv */
// Qualification timer: done once the level has held for the given number of cycles
`timescale 1ns/1ps
module hold_timer #(
	parameter int unsigned W = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Control
	input  wire logic         clr,
	input  wire logic         level,
	input  wire logic [W-1:0] limit,
	// Result
	output logic              done
);

	logic [W-1:0] cnt_q;

	// Count while the level holds, restart on any drop or clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (clr || !level) begin
				cnt_q <= '0;
			end else if (cnt_q < limit) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign done = level && !clr && (cnt_q >= limit);

endmodule : hold_timer

/* File: inc/chg_prot_pkg.sv */
// Package of register map, field positions and timing constants for the protection supervisor
package chg_prot_pkg;

	// ------------------------------------------------------------
	// Register offsets and widths
	// ------------------------------------------------------------
	localparam int unsigned REG_AW            = 8;
	localparam int unsigned REG_DW            = 16;
	localparam logic [7:0]  OFS_INFO_ONE      = 8'h3a;
	localparam logic [7:0]  OFS_CTRL_ONE      = 8'h3c;
	localparam logic [7:0]  OFS_CTRL_TWO      = 8'h3d;
	localparam logic [15:0] CTRL_ONE_RESET    = 16'h0000;
	localparam logic [15:0] CTRL_TWO_RESET    = 16'h0000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned C1_REV_EN_BIT     = 11;
	localparam int unsigned C2_BOV_DIS_BIT    = 0;
	localparam int unsigned C2_WOC_DIS_BIT    = 1;
	localparam int unsigned C2_CMP_POL_BIT    = 2;
	localparam int unsigned C2_CMP_DIS_BIT    = 3;
	localparam int unsigned C2_WOC_RETRY_BIT  = 11;
	localparam int unsigned I1_MODE_LO_BIT    = 5;
	localparam int unsigned I1_MODE_HI_BIT    = 6;
	localparam logic [1:0]  I1_MODE_REVERSE   = 2'h3;
	localparam logic [1:0]  I1_MODE_IDLE      = 2'h0;

	// ------------------------------------------------------------
	// Timing, in printed units, and derived cycle counts
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ           = 10;
	localparam int unsigned ADP_QUAL_US       = 10;
	localparam int unsigned ADP_REL_US        = 100;
	localparam int unsigned BOV_MS            = 1;
	localparam int unsigned WOC_SLOT_US       = 10;
	localparam int unsigned WOC_WIN_MS        = 50;
	localparam int unsigned WOC_RETRY_LONG_MS = 1300;
	localparam int unsigned WOC_RETRY_SHRT_MS = 150;
	localparam int unsigned OT_RESTART_US     = 100;
	localparam int unsigned WOC_TRIP_COUNT    = 7;

	localparam int unsigned ADP_QUAL_CYC      = ADP_QUAL_US * CLK_MHZ;
	localparam int unsigned ADP_REL_CYC       = ADP_REL_US * CLK_MHZ;
	localparam int unsigned WOC_SLOT_CYC      = WOC_SLOT_US * CLK_MHZ;
	localparam int unsigned OT_RESTART_CYC    = OT_RESTART_US * CLK_MHZ;
	localparam int unsigned BOV_CYC           = BOV_MS * CLK_MHZ * 1000;
	localparam int unsigned WOC_WIN_CYC       = WOC_WIN_MS * CLK_MHZ * 1000;
	localparam int unsigned WOC_RETRY_LONG_CYC = WOC_RETRY_LONG_MS * CLK_MHZ * 1000;
	localparam int unsigned WOC_RETRY_SHRT_CYC = WOC_RETRY_SHRT_MS * CLK_MHZ * 1000;

	// Shared pin mode, from reverse enable bit and comparator disable bit
	typedef enum logic [1:0] {
		MODE_CMP_ONLY,
		MODE_ALL_OFF,
		MODE_REV_CMP,
		MODE_REV_PIN
	} pin_mode_t;

	typedef enum logic {
		WOC_WATCH,
		WOC_SHUTDOWN
	} woc_state_t;

endpackage : chg_prot_pkg
